// [dhip_defs.svh]
/*
  dhip_defs.svh: constants of the host event posting block (status bit positions,
  counter loads, widths).
  Assumes: included by the package and the design file by its bare name.
*/
`ifndef DHIP_DEFS_SVH
`define DHIP_DEFS_SVH

// ----------------------------------------------------------------------------
// register map (AHB-Lite byte addresses)
// ----------------------------------------------------------------------------
`define DHIP_STATUS_ADDR 12'h000
`define DHIP_MASK_ADDR 12'h004
`define DHIP_CTRL_ADDR 12'h008
`define DHIP_MARGIN_ADDR 12'h00C
`define DHIP_STATE_ADDR 12'h010

// ----------------------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------------------
`define DHIP_BIT_DATA_ERR 0
`define DHIP_BIT_PIC_SHOWN 1
`define DHIP_BIT_GRP_SHOWN 2
`define DHIP_BIT_SEQ_SHOWN 3
`define DHIP_BIT_LAST_PIC 4
`define DHIP_BIT_SEQ_END 5
`define DHIP_BIT_PIC_DEC 6
`define DHIP_BIT_UNDERFLOW 8
`define DHIP_BIT_SEQ_HDR 9
`define DHIP_BIT_READY 10
`define DHIP_BIT_SCAN_DONE 11
`define DHIP_VALID_BITS 16'h0F7F
// field-sync class: picture, group and sequence shown
`define DHIP_FSYNC_BITS 16'h000E
// ctrl register: bit0 pin release (write 1), bit1 blank, bit2 run, bit3 idle
`define DHIP_CTRL_RELEASE 0
`define DHIP_CTRL_BLANK 1
`define DHIP_CTRL_RUN 2
`define DHIP_CTRL_IDLE 3

// ----------------------------------------------------------------------------
// line counter constants
// ----------------------------------------------------------------------------
`define DHIP_BOTTOM_BASE 10'h0FF
`define DHIP_BLANK_SUM 10'h00F
`define DHIP_RESET_MARGIN 8'h10
`define DHIP_RESET_HEIGHT 8'hF0

`endif

// [dhip_host_model.sv]
/*
  dhip_host_model.sv: host processor model that reads and clears the event
  status word and releases the interrupt pin over AHB-Lite.
  Assumes: sole bus master, hready looped from the slave's hreadyout,
  tb_top owns the error counter and the closing report.
*/
`timescale 1ns/1ps
`include "dhip_defs.svh"

module dhip_host_model (
  // clock
  input wire logic clk,
  // AHB-Lite master side
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // mode bits repeated on every pin release so blank/run/idle survive
  logic [31:0] ctrlKeep = 32'h0000000A;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // bounded wait for hready; a hang ends the run through the report
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      tb_top.errCount++;
      tb_top.finishTest();
    end
  endtask : waitReady

  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    waitReady();
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask : xfer

  // write the mode bits and remember them
  task automatic setCtrl(input logic [31:0] v);
    logic [31:0] q;
    ctrlKeep = v;
    xfer(1'b1, `DHIP_CTRL_ADDR, v, q);
  endtask : setCtrl

  // service routine: read; only for a nonzero word, clear it and release the pin
  task automatic service(output logic [31:0] seen);
    logic [31:0] q;
    xfer(1'b0, `DHIP_STATUS_ADDR, 32'h0, seen);
    if (seen !== 32'h0) begin
      xfer(1'b1, `DHIP_STATUS_ADDR, 32'h0, q);
      xfer(1'b1, `DHIP_CTRL_ADDR, ctrlKeep | 32'h1, q);
    end
  endtask : service
endmodule : dhip_host_model

// [dhip_irq_posting.sv]
/*
  dhip_irq_posting.sv: display-time scheduling, event queue, status word and
  active-low interrupt pin of the decoder, with an AHB-Lite register slave.
  Assumes: one clock, synchronous sync and event strobes, a single AHB master
  with this slave's hreadyout used as hready, and a host that obeys the
  status word handshake.
*/
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "dhip_defs.svh"

// Overview of operation
// - bottom border loads 255 minus margin plus height
// - decrement per line sync, opportunity at low bits zero
// - last opportunity at zero, then wait field sync
// - blanked: whole field bottom border, sum 15
// - enabled decode events raise, even while blanked
// - field-sync events only on first new picture
// - no field-sync events for repeated pictures
// - no field-sync events while output blanked
// - status bits and pin low set together
// - one bit per source, mask bit order
// - device writes status only when zero
// - zero status posts queue, else queue merges
// - queued events wait for next opportunity
// - every timing condition is a posting opportunity
// - queue only enabled events, still post queue
// - fixed bit positions, unused bits zero
// - top border counter from margin, low bits zero
// - no new events halted, idle, masked, or pending; code gates only on halt, idle and an all-zero mask
module dhip_irq_posting
  import dhip_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // video timing
  input wire logic lineSync,
  input wire logic fieldSync,
  input wire logic [7:0] activeHeight,
  input wire logic firstNewPicture,
  // decode events, one-cycle strobes in status bit order
  input wire logic [15:0] decodeEvents,
  // interrupt pin
  output logic intPin_n
);

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  logic wrPend; // data phase of a write
  logic [11:0] wrAddr; // latched write address
  dhip_word_t statusWord; // shared status word
  dhip_word_t eventMask; // event enable mask
  dhip_word_t queuedEvents; // pending queue
  logic blankOutput; // blank output command
  logic cpuRun; // embedded processor running
  logic idleState; // decoder idle
  logic [7:0] topMarginLines; // top margin in lines
  logic [9:0] lineCnt; // border line counter
  dhip_region_e region; // current part of the field

  // decode of the status address, used by the read and write paths
  function automatic logic isStatus(input logic [11:0] a);
    return a == `DHIP_STATUS_ADDR;
  endfunction : isStatus

  wire addrPhase = hsel && hready && htrans[1];
  wire hostWrStatus = wrPend && isStatus(wrAddr);
  wire hostWrCtrl = wrPend && (wrAddr == `DHIP_CTRL_ADDR);

  // zero wait states; always OKAY
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // capture the address phase of writes
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
    end else begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr;
    end
  end

  // read data registered in the address phase; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      if (isStatus(haddr)) begin
        hrdata <= {16'h0000, statusWord};
      end else if (haddr == `DHIP_MASK_ADDR) begin
        hrdata <= {16'h0000, eventMask};
      end else if (haddr == `DHIP_CTRL_ADDR) begin
        hrdata <= {28'h0000000, idleState, cpuRun, blankOutput, ~intPin_n};
      end else if (haddr == `DHIP_MARGIN_ADDR) begin
        hrdata <= {24'h000000, topMarginLines};
      end else if (haddr == `DHIP_STATE_ADDR) begin
        hrdata <= {16'h0000, queuedEvents};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      eventMask <= 16'h0000;
      blankOutput <= 1'b1;
      cpuRun <= 1'b0;
      idleState <= 1'b1;
      topMarginLines <= `DHIP_RESET_MARGIN;
    end else if (wrPend) begin
      if (wrAddr == `DHIP_MASK_ADDR) begin
        eventMask <= hwdata[15:0] & `DHIP_VALID_BITS;
      end else if (hostWrCtrl) begin
        blankOutput <= hwdata[`DHIP_CTRL_BLANK];
        cpuRun <= hwdata[`DHIP_CTRL_RUN];
        idleState <= hwdata[`DHIP_CTRL_IDLE];
      end else if (wrAddr == `DHIP_MARGIN_ADDR) begin
        topMarginLines <= hwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // display-time opportunities
  // --------------------------------------------------------------------------
  logic lineSyncQ; // previous line sync, falling edge active
  logic fieldSyncQ; // previous field sync, rising edge active
  wire lineEdge = lineSyncQ && !lineSync;
  wire fieldEdge = !fieldSyncQ && fieldSync;

  always_ff @(posedge clk) begin
    if (srst) begin
      lineSyncQ <= 1'b1;
      fieldSyncQ <= 1'b0;
    end else begin
      lineSyncQ <= lineSync;
      fieldSyncQ <= fieldSync;
    end
  end

  // bottom border load: 255 minus (margin + height), or sum 15 when blanked
  wire [9:0] borderSum = blankOutput ? `DHIP_BLANK_SUM :
    (10'(topMarginLines) + 10'(activeHeight));
  wire [9:0] bottomLoad = `DHIP_BOTTOM_BASE - borderSum;
  wire bottomEmpty = borderSum >= `DHIP_BOTTOM_BASE; // zero or negative
  wire [9:0] cntDec = lineCnt - 10'h001;
  logic [7:0] activeLeft; // lines left in the active region

  // counter walks top border, active region, bottom border, then waits
  always_ff @(posedge clk) begin
    if (srst) begin
      region <= DHIP_DONE;
      lineCnt <= 10'd0;
      activeLeft <= 8'h00;
    end else if (fieldEdge) begin
      // a field sync restarts the sequence; it must follow the count-out
      if (blankOutput) begin
        region <= bottomEmpty ? DHIP_DONE : DHIP_BOTTOM;
        lineCnt <= bottomLoad;
      end else if (topMarginLines == 8'h00) begin
        // no top border: a zero load would wrap and count 1024 lines
        region <= DHIP_ACTIVE;
        activeLeft <= activeHeight;
      end else begin
        region <= DHIP_TOP;
        lineCnt <= 10'(topMarginLines);
      end
    end else if (lineEdge) begin
      case (region)
        DHIP_TOP: begin
          lineCnt <= cntDec;
          if (cntDec == 10'd0) begin
            region <= DHIP_ACTIVE;
            activeLeft <= activeHeight;
          end
        end
        DHIP_ACTIVE: begin
          activeLeft <= activeLeft - 8'h01;
          if (activeLeft <= 8'h01) begin
            region <= bottomEmpty ? DHIP_DONE : DHIP_BOTTOM;
            lineCnt <= bottomLoad;
          end
        end
        DHIP_BOTTOM: begin
          lineCnt <= cntDec;
          if (cntDec == 10'd0) begin
            region <= DHIP_DONE;
          end
        end
        default: begin
          lineCnt <= lineCnt;
        end
      endcase
    end
  end

  // opportunity when the decremented counter has its low three bits zero
  wire dispOpp = lineEdge && (region == DHIP_TOP || region == DHIP_BOTTOM)
    && (cntDec[2:0] == 3'b000);

  // --------------------------------------------------------------------------
  // event collection and posting
  // --------------------------------------------------------------------------
  wire dispEn = !idleState; // not idle, so not in play setup either
  // field-sync class only on first display of a new picture, never blanked
  wire fsyncOpp = fieldEdge && firstNewPicture && !blankOutput;
  wire decOpp = |(decodeEvents & `DHIP_VALID_BITS);
  wire [15:0] fsyncEvents = fsyncOpp ? `DHIP_FSYNC_BITS : 16'h0000;
  wire [15:0] dispEvents = dispOpp ? (16'h0001 << `DHIP_BIT_READY) : 16'h0000;
  // candidates masked by the enable mask and the valid bit layout
  wire [15:0] newEvents = (decodeEvents | fsyncEvents | dispEvents)
    & eventMask & `DHIP_VALID_BITS;
  wire genAllowed = cpuRun && dispEn && (eventMask != 16'h0000);
  wire postOpp = genAllowed && (dispOpp || fsyncOpp || decOpp);
  wire [15:0] merged = queuedEvents | newEvents;
  wire doPost = postOpp && (statusWord == 16'h0000) && (merged != 16'h0000);

  // queue: merges while status busy, cleared in the posting cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      queuedEvents <= 16'h0000;
    end else if (doPost) begin
      queuedEvents <= 16'h0000;
    end else if (postOpp) begin
      queuedEvents <= merged;
    end
  end

  // status word: device posts only when zero, host clears by writing
  always_ff @(posedge clk) begin
    if (srst) begin
      statusWord <= 16'h0000;
    end else if (doPost) begin
      statusWord <= merged;
    end else if (hostWrStatus) begin
      statusWord <= hwdata[15:0] & `DHIP_VALID_BITS;
    end
  end

  // pin goes low with the status write and stays low until released
  always_ff @(posedge clk) begin
    if (srst) begin
      intPin_n <= 1'b1;
    end else if (doPost) begin
      intPin_n <= 1'b0;
    end else if (hostWrCtrl && hwdata[`DHIP_CTRL_RELEASE]) begin
      intPin_n <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_post_pin;
    @(posedge clk) disable iff (srst) doPost |=> (!intPin_n && statusWord != 16'h0000);
  endproperty
  a_post_pin: assert property (p_post_pin) else $error("post without pin and status");

  property p_only_zero;
    @(posedge clk) disable iff (srst)
      ($past(statusWord) != 16'h0000 && !$past(hostWrStatus)) |-> $stable(statusWord);
  endproperty
  a_only_zero: assert property (p_only_zero) else $error("status written while busy");

  property p_unused_zero;
    @(posedge clk) disable iff (srst) (statusWord & ~`DHIP_VALID_BITS) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");

  property p_queue_clear;
    @(posedge clk) disable iff (srst) doPost |=> queuedEvents == 16'h0000;
  endproperty
  a_queue_clear: assert property (p_queue_clear) else $error("queue not cleared");

  property p_pin_hold;
    @(posedge clk) disable iff (srst)
      (!intPin_n && !(hostWrCtrl && hwdata[`DHIP_CTRL_RELEASE])) |=> !intPin_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin released early");

  property p_no_gen;
    @(posedge clk) disable iff (srst)
      !genAllowed |=> $stable(queuedEvents) || queuedEvents == 16'h0000;
  endproperty
  a_no_gen: assert property (p_no_gen) else $error("event generated while inhibited");

  property p_no_fsync_blank;
    @(posedge clk) disable iff (srst) (blankOutput && !doPost) |=>
      ((queuedEvents & ~$past(queuedEvents) & `DHIP_FSYNC_BITS) == 16'h0000);
  endproperty
  a_no_fsync_blank: assert property (p_no_fsync_blank) else $error("field event while blank");

  property p_bottom_done;
    @(posedge clk) disable iff (srst)
      (lineEdge && region == DHIP_BOTTOM && cntDec == 10'd0 && !fieldEdge) |=> region == DHIP_DONE;
  endproperty
  a_bottom_done: assert property (p_bottom_done) else $error("bottom count-out missed");

  // leaving the active region loads the bottom counter from the border sum
  property p_bottom_load;
    @(posedge clk) disable iff (srst)
      (lineEdge && !fieldEdge && region == DHIP_ACTIVE && activeLeft <= 8'h01 && !bottomEmpty)
      |=> (region == DHIP_BOTTOM && lineCnt == `DHIP_BOTTOM_BASE - $past(borderSum));
  endproperty
  a_bottom_load: assert property (p_bottom_load) else $error("bottom load wrong");

  // an enabled ready opportunity on a free word must show in the word
  property p_disp_ready;
    @(posedge clk) disable iff (srst)
      (dispOpp && genAllowed && statusWord == 16'h0000 && eventMask[`DHIP_BIT_READY])
      |=> statusWord[`DHIP_BIT_READY];
  endproperty
  a_disp_ready: assert property (p_disp_ready) else $error("ready opportunity lost");

  // a busy word sends new enabled events into the queue, none dropped
  property p_queue_merge;
    @(posedge clk) disable iff (srst)
      (postOpp && statusWord != 16'h0000) |=> ((queuedEvents & $past(newEvents)) == $past(newEvents));
  endproperty
  a_queue_merge: assert property (p_queue_merge) else $error("event not queued");

  // while inhibited a free word stays free unless the host writes it
  property p_quiet_status;
    @(posedge clk) disable iff (srst)
      (!genAllowed && statusWord == 16'h0000 && !hostWrStatus) |=> statusWord == 16'h0000;
  endproperty
  a_quiet_status: assert property (p_quiet_status) else $error("post while inhibited");

endmodule : dhip_irq_posting

// [dhip_pkg.sv]
/*
  dhip_pkg.sv: types of the host event posting block.
  Assumes: dhip_defs.svh is on the include path.
*/
package dhip_pkg;
  `include "dhip_defs.svh"

  // border region the line counter is walking through
  typedef enum logic [1:0] {
    DHIP_TOP,
    DHIP_ACTIVE,
    DHIP_BOTTOM,
    DHIP_DONE
  } dhip_region_e;

  typedef logic [15:0] dhip_word_t;
endpackage : dhip_pkg

// [tb_top.sv]
/*
  tb_top.sv: self-checking bench of the event posting block.
  Assumes: the host model drives the bus; sync and event strobes come from here.
*/
`timescale 1ns/1ps
`include "dhip_defs.svh"

module tb_top
  import dhip_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, srst, hsel, hwrite, hreadyout, hresp, lineSync, fieldSync;
  logic firstNewPicture, intPin_n;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [7:0] activeHeight;
  dhip_word_t decodeEvents;
  int errCount = 0;
  int totalChecks = 0;

  dhip_irq_posting dhip_irq_posting_i (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lineSync(lineSync), .fieldSync(fieldSync), .activeHeight(activeHeight),
    .firstNewPicture(firstNewPicture), .decodeEvents(decodeEvents), .intPin_n(intPin_n));

  dhip_host_model dhip_host_model_i (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finishTest

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    dhip_host_model_i.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    dhip_host_model_i.xfer(1'b1, a, d, q);
  endtask : wr

  // one-cycle strobe, then one edge so the posting has landed
  task automatic strobe(input dhip_word_t v);
    decodeEvents <= v;
    @(posedge clk);
    decodeEvents <= 16'h0000;
    @(posedge clk);
  endtask : strobe

  // one falling line edge, then the host services the word
  task automatic lineEdge(output logic [31:0] q);
    lineSync <= 1'b0;
    @(posedge clk);
    lineSync <= 1'b1;
    @(posedge clk);
    dhip_host_model_i.service(q);
  endtask : lineEdge

  // field edge, field events seen, then ready posts counted over the lines
  task automatic runField(input logic fresh, input logic [31:0] expEvt, input int lines,
                          output int cnt, output int first);
    logic [31:0] q;
    firstNewPicture <= fresh;
    fieldSync <= 1'b1;
    repeat (2) @(posedge clk);
    fieldSync <= 1'b0;
    repeat (2) @(posedge clk);
    dhip_host_model_i.service(q);
    check("field events", q, expEvt);
    cnt = 0;
    first = 0;
    for (int i = 1; i <= lines; i++) begin
      lineEdge(q);
      if (q === 32'h00000400) begin
        cnt++;
        if (first == 0) first = i;
      end
    end
  endtask : runField

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    logic [11:0] a[6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h020};
    logic [31:0] e[6] = '{32'h0, 32'h0, 32'hA, 32'h10, 32'h0, 32'h0};
    logic [31:0] q;
    check("pin idle", {31'h0, intPin_n}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
    foreach (a[i]) begin
      rd(a[i], q);
      check("reset value", q, e[i]);
    end
  endtask : testReset

  task automatic testDecode();
    int bits[7] = '{0, 4, 5, 6, 8, 9, 11};
    logic [31:0] q;
    wr(`DHIP_MASK_ADDR, 32'h0E7F);
    dhip_host_model_i.setCtrl(32'h6);
    strobe(16'h0200);
    check("pin set", {31'h0, intPin_n}, 32'h0);
    strobe(16'h0040);
    rd(`DHIP_STATUS_ADDR, q);
    check("status held", q, 32'h0200);
    rd(`DHIP_STATE_ADDR, q);
    check("queued", q, 32'h0040);
    wr(`DHIP_STATUS_ADDR, 32'h0);
    rd(`DHIP_STATE_ADDR, q);
    check("queue waits", q, 32'h0040);
    check("pin still low", {31'h0, intPin_n}, 32'h0);
    strobe(16'h0100);
    rd(`DHIP_STATUS_ADDR, q);
    check("queue posted", q, 32'h0040);
    wr(`DHIP_STATUS_ADDR, 32'hFFFF);
    rd(`DHIP_STATUS_ADDR, q);
    check("unused bits", q, 32'h0F7F);
    dhip_host_model_i.service(q);
    // the release lands on the edge the service ends on; let it settle
    @(posedge clk);
    check("pin released", {31'h0, intPin_n}, 32'h1);
    wr(`DHIP_MASK_ADDR, 32'h0F7F);
    foreach (bits[i]) begin
      strobe(16'h0001 << bits[i]);
      dhip_host_model_i.service(q);
      check("decode bit", q, 32'h1 << bits[i]);
    end
    dhip_host_model_i.setCtrl(32'hE);
    strobe(16'h0200);
    rd(`DHIP_STATUS_ADDR, q);
    check("idle quiet", q, 32'h0);
    dhip_host_model_i.setCtrl(32'h6);
    wr(`DHIP_MASK_ADDR, 32'h0);
    strobe(16'h0200);
    rd(`DHIP_STATUS_ADDR, q);
    check("masked quiet", q, 32'h0);
    wr(`DHIP_MASK_ADDR, 32'h0F7F);
  endtask : testDecode

  task automatic testFields();
    int c, f;
    runField(1'b1, 32'h0, 260, c, f);
    check("blank count", c, 30);
    check("blank first", f, 8);
    dhip_host_model_i.setCtrl(32'h4);
    wr(`DHIP_MARGIN_ADDR, 32'h4);
    runField(1'b1, `DHIP_FSYNC_BITS, 300, c, f);
    check("field count", c, 20);
    activeHeight <= 8'd252;
    runField(1'b0, 32'h0, 300, c, f);
    check("no bottom", c, 1);
  endtask : testFields

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    lineSync = 1'b1;
    fieldSync = 1'b0;
    activeHeight = 8'd100;
    firstNewPicture = 1'b0;
    decodeEvents = 16'h0000;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    testReset();
    testDecode();
    testFields();
    finishTest();
  end

  initial begin
    repeat (100000) @(posedge clk);
    errCount++;
    finishTest();
  end
endmodule : tb_top
